//--- hdl/qie_out_stage.sv
// Quadrature channel and index output stage of the incremental position sensor
`timescale 1ns/10ps
module qie_out_stage #(
  parameter int unsigned PWRUP_CYCLES = qie_pkg::POWER_UP_LOCK_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [9:0] i_fine_pos,
  input wire qie_pkg::qie_status_t i_status,
  input wire logic i_open_drain,
  output qie_pkg::qie_pins_t o_pin_level,
  output qie_pkg::qie_pins_t o_pin_oe_n,
  output logic o_enabled,
  output logic o_lock_timeout,
  output logic o_lag_error,
  output logic [7:0] o_step
);

  // Counter terminal values, cut to the counter widths on purpose
  localparam logic [14:0] PWRUP_LAST = 15'(PWRUP_CYCLES - 1);
  localparam logic [9:0] PROP_LAST = 10'(qie_pkg::PROP_CYCLES - 1);

  qie_pkg::qie_state_t state;
  qie_pkg::qie_state_t next_state;
  logic [14:0] pwrup_cnt;
  logic [14:0] next_pwrup_cnt;
  logic pwrup_expired;
  logic lock_ok;
  logic weak_field;
  logic [9:0] lag_cnt;
  logic [9:0] next_lag_cnt;
  logic lag_limit;
  logic next_lag_error;
  logic [7:0] step;
  logic settled;
  logic load_step;
  logic [1:0] quad_phase;
  logic [1:0] quad_ab;
  logic at_index;
  qie_pkg::qie_pins_t run_level;
  qie_pkg::qie_pins_t next_level;
  qie_pkg::qie_pins_t next_oe_n;
  qie_pkg::qie_pins_t level;
  logic drive_on;

  // Front-end qualifiers
  assign lock_ok = i_status.amp_valid && i_status.locked;
  assign weak_field = i_status.field_low || !i_status.amp_valid;

  // Output state machine: no pin is driven before the interpolator locks
  // Field loss never releases the pins again, since pulled-up wires would read as a false index
  always_comb
  begin
    next_state = state;
    unique case (state)
      qie_pkg::ST_DISABLED:
        if (lock_ok)
          next_state = qie_pkg::ST_RUN;
      qie_pkg::ST_RUN:
        if (weak_field)
          next_state = qie_pkg::ST_FIELD_LOW;
      qie_pkg::ST_FIELD_LOW:
        if (!weak_field && i_status.locked)
          next_state = qie_pkg::ST_RUN;
      default:
        next_state = qie_pkg::ST_DISABLED;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      state <= qie_pkg::ST_DISABLED;
    else
      state <= next_state;
  end

  // Power-up watchdog: flags a front end that has not locked in time
  // It only flags; enabling still waits for a real lock so no pin shows a false position
  assign pwrup_expired = pwrup_cnt == PWRUP_LAST;
  assign next_pwrup_cnt = (state != qie_pkg::ST_DISABLED || pwrup_expired) ? pwrup_cnt
                                                                           : pwrup_cnt + 15'h0001;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pwrup_cnt <= 15'h0000;
      o_lock_timeout <= 1'b0;
    end
    else
    begin
      pwrup_cnt <= next_pwrup_cnt;
      o_lock_timeout <= pwrup_expired && state == qie_pkg::ST_DISABLED;
    end
  end

  // Step is reloaded from the input while disabled, so enabling causes no run of edges
  assign load_step = state == qie_pkg::ST_DISABLED;

  // The tracker walks one step per clock, so input jumps still give clean quadrature edges
  qie_step_tracker u_tracker (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_fine_pos(i_fine_pos),
    .i_load(load_step),
    .o_step(step),
    .o_settled(settled)
  );

  // Lag watchdog: tracker moves one step a clock, far faster than the magnet
  // Limitation: a jump of more than half a pole pair is followed the short way round
  assign lag_limit = lag_cnt == PROP_LAST;
  assign next_lag_cnt = (settled || load_step) ? 10'h000 : lag_limit ? lag_cnt : lag_cnt + 10'h001;
  assign next_lag_error = lag_limit && !settled && !load_step;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      lag_cnt <= 10'h000;
      o_lag_error <= 1'b0;
    end
    else
    begin
      lag_cnt <= next_lag_cnt;
      o_lag_error <= next_lag_error;
    end
  end

  // Step modulo 4 gives 40 Gray cycles in 160 steps
  assign quad_phase = step[1:0];

  // Forward: 11, 01, 00, 10; channel one changes first, one bit per step
  // A downstream counter takes the direction from whichever channel moves first
  assign quad_ab = (quad_phase == 2'h0) ? qie_pkg::QUAD_PH0 :
                   (quad_phase == 2'h1) ? qie_pkg::QUAD_PH1 :
                   (quad_phase == 2'h2) ? qie_pkg::QUAD_PH2 : qie_pkg::QUAD_PH3;

  // Index only on the reference step, dropping one step either way
  // Step 0 is the only index step, so one pulse comes per 40 quadrature cycles
  assign at_index = step == qie_pkg::INDEX_STEP;

  // Running pattern; reference step falls on phase 0 so both channels read high
  assign run_level.chan_a = quad_ab[1];
  assign run_level.chan_b = quad_ab[0];
  assign run_level.idx = at_index;

  // Weak field overrides with a pattern that cannot occur while running
  always_comb
  begin
    next_level = '0;
    unique case (state)
      qie_pkg::ST_RUN:
        next_level = run_level;
      qie_pkg::ST_FIELD_LOW:
      begin
        next_level.idx = 1'b1;
        next_level.chan_a = 1'b0;
        next_level.chan_b = 1'b0;
      end
      default:
        next_level = '0;
    endcase
  end

  // Pins are released entirely until the first lock
  assign drive_on = state != qie_pkg::ST_DISABLED;

  // Per-pin driver: push-pull drives both levels, open-drain only pulls low
  // Open-drain releases a high pin instead of driving it, so the external pull-up sets the level
  genvar gi;
  generate
    for (gi = 0; gi < qie_pkg::NUM_PINS; gi = gi + 1)
    begin : g_pin
      assign next_oe_n[gi] = !drive_on || (i_open_drain && next_level[gi]);
    end
  endgenerate

  // Output registers; one clock of latency, well inside the propagation budget
  // Level and enable share one register stage, so every pin changes on a single edge
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      level <= '0;
      o_pin_oe_n <= '1;
    end
    else
    begin
      level <= next_level;
      o_pin_oe_n <= next_oe_n;
    end
  end

  // Open-drain pins only ever drive a low level
  generate
    for (gi = 0; gi < qie_pkg::NUM_PINS; gi = gi + 1)
    begin : g_lvl
      assign o_pin_level[gi] = level[gi] && !i_open_drain;
    end
  endgenerate

  // Status outputs
  // Enabled also covers open-drain with every pin released high at the index step
  assign o_enabled = !o_pin_oe_n.chan_a || !o_pin_oe_n.chan_b || !o_pin_oe_n.idx || (level != '0);
  assign o_step = step;

endmodule : qie_out_stage

//--- hdl/qie_pkg.sv
// Constants and types shared by the quadrature and index output stage
package qie_pkg;

  // Interpolation geometry of one magnetic pole pair
  localparam int unsigned STEPS_PER_PP = 160;
  localparam int unsigned QUAD_CYCLES_PER_PP = 40;
  localparam int unsigned STEPS_PER_QUAD = STEPS_PER_PP / QUAD_CYCLES_PER_PP;
  localparam int unsigned STEP_W = 8;
  localparam logic [7:0] STEP_LAST = 8'h9f;
  localparam logic [7:0] INDEX_STEP = 8'h00;

  // Fine input position: four sub-steps per step, 640 per pole pair
  localparam int unsigned SUB_PER_STEP = 4;
  localparam int unsigned FINE_W = 10;
  localparam logic [10:0] FINE_PER_PP = 11'h280;
  localparam logic [10:0] FINE_HALF_PP = 11'h140;

  // Hysteresis in sub-steps: one full step, inside the 1 to 2 step band
  localparam logic [10:0] HYST_SUB = 11'h004;
  localparam logic [10:0] STEP_SUB = 11'h004;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned POWER_UP_LOCK_TIME_US = 500;
  localparam int unsigned POWER_UP_LOCK_CYCLES = (POWER_UP_LOCK_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned PROP_TIME_US = 20;
  localparam int unsigned PROP_CYCLES = (PROP_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned PWRUP_CNT_W = 15;
  localparam int unsigned PROP_CNT_W = 10;

  // Channel phase pattern indexed by step modulo 4, bit 1 is channel one
  localparam logic [1:0] QUAD_PH0 = 2'h3;
  localparam logic [1:0] QUAD_PH1 = 2'h1;
  localparam logic [1:0] QUAD_PH2 = 2'h0;
  localparam logic [1:0] QUAD_PH3 = 2'h2;

  // Pin bundle: channel one, channel two and index
  localparam int unsigned NUM_PINS = 3;
  typedef struct packed {
    logic idx;
    logic chan_b;
    logic chan_a;
  } qie_pins_t;

  // Front-end status from the analog path
  typedef struct packed {
    logic amp_valid;
    logic locked;
    logic field_low;
  } qie_status_t;

  typedef enum logic [1:0] {
    ST_DISABLED = 2'b00,
    ST_RUN = 2'b01,
    ST_FIELD_LOW = 2'b10
  } qie_state_t;

endpackage : qie_pkg

//--- hdl/qie_step_tracker.sv
// Step tracker with hysteresis between the fine position and the output step
`timescale 1ns/10ps
module qie_step_tracker (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [9:0] i_fine_pos,
  input wire logic i_load,
  output logic [7:0] o_step,
  output logic o_settled
);

  logic [10:0] target;
  logic [10:0] diff_raw;
  logic [10:0] diff_pos;
  logic signed [10:0] diff;
  logic step_fwd;
  logic step_bwd;
  logic [7:0] fine_step;
  logic [7:0] step_inc;
  logic [7:0] step_dec;
  logic [7:0] next_step;

  // Lower edge of the current step in sub-steps
  assign target = {1'b0, o_step, 2'b00};

  // Wrapped signed distance from the step edge, -320 to 319 sub-steps
  assign diff_raw = {1'b0, i_fine_pos} - target;
  assign diff_pos = diff_raw[10] ? diff_raw + qie_pkg::FINE_PER_PP : diff_raw;
  assign diff = (diff_pos >= qie_pkg::FINE_HALF_PP) ? $signed(diff_pos - qie_pkg::FINE_PER_PP)
                                                   : $signed(diff_pos);

  // Forward at the next boundary, backward only past the hysteresis band
  assign step_fwd = diff >= $signed(qie_pkg::STEP_SUB);
  assign step_bwd = diff < -$signed(qie_pkg::HYST_SUB);
  assign o_settled = !step_fwd && !step_bwd;

  // Step arithmetic wraps inside the pole pair
  assign fine_step = i_fine_pos[9:2];
  assign step_inc = (o_step == qie_pkg::STEP_LAST) ? 8'h00 : o_step + 8'h01;
  assign step_dec = (o_step == 8'h00) ? qie_pkg::STEP_LAST : o_step - 8'h01;
  // One step a clock keeps the channels moving one edge at a time
  assign next_step = i_load ? fine_step : step_fwd ? step_inc : step_bwd ? step_dec : o_step;

  // Step register
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_step <= 8'h00;
    else
      o_step <= next_step;
  end

endmodule : qie_step_tracker

//--- tb/qie_out_stage_assertions.sv
// Assertion checker for the quadrature and index output stage
`timescale 1ns/10ps
module qie_out_stage_assertions (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [9:0] i_fine_pos,
  input wire qie_pkg::qie_status_t i_status,
  input wire logic i_open_drain,
  input wire qie_pkg::qie_pins_t o_pin_level,
  input wire qie_pkg::qie_pins_t o_pin_oe_n,
  input wire logic o_enabled,
  input wire logic [7:0] o_step
);
  logic [7:0] prev_step;
  logic [2:0] prev_pins;
  logic lock_seen;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  // Last step and pins; pins lag the step by one cycle
  always_ff @(posedge i_clk)
  begin
    prev_step <= o_step;
    prev_pins <= o_pin_level;
  end
  // Sticky record of a front-end lock since reset
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      lock_seen <= 1'b0;
    else if (i_status.amp_valid && i_status.locked)
      lock_seen <= 1'b1;
  end
  idx_at_ref_a: assert property (o_enabled && o_pin_level == 3'h7 |-> prev_step == 8'h00)
    else $error("index away from step zero");
  quad_map_a: assert property (o_enabled && !i_open_drain && !o_pin_level.idx |->
    {o_pin_level.chan_a, o_pin_level.chan_b} == {~^prev_step[1:0], ~prev_step[1]})
    else $error("channel pair off pattern");
  gray_move_a: assert property (o_enabled && $past(o_enabled) && !i_open_drain &&
    !o_pin_level.idx && !prev_pins[2] |-> $countones(o_pin_level[1:0] ^ prev_pins[1:0]) <= 1)
    else $error("both channels moved");
  pins_released_a: assert property (!lock_seen |-> o_pin_oe_n == 3'h7 && o_pin_level == 3'h0)
    else $error("pins driven while disabled");
  enable_cause_a: assert property ($rose(o_enabled) |-> ($past(i_status, 2) & 3'h6) == 3'h6)
    else $error("enabled without lock");
  weak_field_a: assert property ((o_enabled && !i_open_drain && i_status.field_low) [*3] |-> o_pin_level == 3'h4)
    else $error("weak field code missing");
  od_level_a: assert property (i_open_drain |-> o_pin_level == 3'h0)
    else $error("open drain drives high");
  hyst_fwd_a: assert property ($past(o_enabled) && o_step == prev_step + 8'h01 |->
    $past(i_fine_pos) >= {prev_step, 2'h0} + 10'h004)
    else $error("early forward step");
endmodule : qie_out_stage_assertions

bind qie_out_stage qie_out_stage_assertions u_chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_fine_pos(i_fine_pos),
  .i_status(i_status), .i_open_drain(i_open_drain), .o_pin_level(o_pin_level), .o_pin_oe_n(o_pin_oe_n),
  .o_enabled(o_enabled), .o_step(o_step));

//--- tb/qie_enc_counter.sv
// Encoder counter model that watches the channel and index wires
`timescale 1ns/10ps
module qie_enc_counter (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire qie_pkg::qie_pins_t i_wire,
  output logic [15:0] o_count,
  output logic [7:0] o_marks
);
  logic [1:0] ph;
  logic [1:0] last_ph;
  logic last_mark;
  logic mark;
  logic [1:0] dph;
  // Phase of the wire pair; released wires read as phase zero with a mark
  assign ph = {~i_wire.chan_b, i_wire.chan_a ^ i_wire.chan_b};
  assign mark = &i_wire;
  assign dph = ph - last_ph;
  // Count quarters; a two-phase jump is ambiguous, so it is ignored
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_count <= 16'h0000;
      o_marks <= 8'h00;
      last_ph <= 2'h0;
      last_mark <= 1'b1;
    end
    else
    begin
      o_count <= o_count + (dph == 2'h1 ? 16'h0001 : (dph == 2'h3 ? 16'hffff : 16'h0000));
      o_marks <= o_marks + {7'h00, mark & !last_mark};
      last_ph <= ph;
      last_mark <= mark;
    end
  end
endmodule : qie_enc_counter

//--- tb/qie_out_stage_tb.sv
// Self-checking bench for the quadrature and index output stage
`timescale 1ns/10ps
module qie_out_stage_tb;
  logic i_clk;
  logic i_nrst;
  logic [9:0] fine;
  qie_pkg::qie_status_t status;
  logic od;
  qie_pkg::qie_pins_t lvl;
  qie_pkg::qie_pins_t oe_n;
  qie_pkg::qie_pins_t pin;
  logic en;
  logic [7:0] step;
  logic [15:0] cnt;
  logic [7:0] marks;
  logic lock_to;
  logic lag_err;
  int errors;
  int check_count;
  // Released pins float to the pull-up level
  assign pin = oe_n | lvl;
  qie_out_stage #(.PWRUP_CYCLES(50)) uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_fine_pos(fine), .i_status(status),
    .i_open_drain(od), .o_pin_level(lvl), .o_pin_oe_n(oe_n), .o_enabled(en), .o_lock_timeout(lock_to),
    .o_lag_error(lag_err), .o_step(step));
  qie_enc_counter model (.i_clk(i_clk), .i_nrst(i_nrst), .i_wire(pin), .o_count(cnt), .o_marks(marks));
  // 40 MHz clock
  initial
  begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask : cyc
  task automatic do_reset(input logic mode);
    od = mode;
    status = 3'h0;
    fine = 10'h002;
    i_nrst = 1'b0;
    cyc(10);
    i_nrst = 1'b1;
  endtask : do_reset
  // Wire pattern {index, B, A} expected at a step
  function automatic logic [2:0] pat(input int s);
    logic [2:0] t [4];
    t = '{3'h3, 3'h2, 3'h0, 3'h1};
    return t[s % 4] | {s == 0, 2'h0};
  endfunction : pat
  task automatic go(input int s, input int f);
    fine = 10'(f);
    cyc(3);
    chk(pin, pat(s));
  endtask : go
  task automatic t_lock;
    cyc(5);
    chk(oe_n, 3'h7);
    chk(lock_to, 1'b0);
    cyc(50);
    chk(lock_to, 1'b1);
    status = 3'h6;
    cyc(3);
    chk({en, oe_n}, 4'h8);
    chk(lock_to, 1'b0);
  endtask : t_lock
  // Forward over a whole pole pair, index seen on the wrap
  task automatic t_fwd;
    for (int s = 1; s <= 160; s++)
      go(s % 160, (4 * s + 2) % 640);
    chk(cnt, 16'h00a0);
    chk(marks, 8'h01);
  endtask : t_fwd
  // Backward needs the position below the step edge by more than the hysteresis
  task automatic t_rev;
    for (int s = 159; s >= 0; s--)
      go(s, (4 * s + 639) % 640);
    chk(cnt, 16'h0000);
    chk(marks, 8'h02);
  endtask : t_rev
  task automatic t_hyst;
    fine = 10'h02a;
    cyc(14);
    chk(step, 8'h0a);
    chk(lag_err, 1'b0);
    fine = 10'h025;
    cyc(4);
    chk(step, 8'h0a);
    fine = 10'h023;
    cyc(3);
    chk(step, 8'h09);
    fine = 10'h027;
    cyc(3);
    chk(step, 8'h09);
    fine = 10'h028;
    cyc(3);
    chk(step, 8'h0a);
  endtask : t_hyst
  task automatic t_weak;
    status = 3'h7;
    cyc(3);
    chk(pin, 3'h4);
    status = 3'h6;
    cyc(4);
    chk(pin, 3'h0);
    status = 3'h2;
    cyc(3);
    chk(pin, 3'h4);
    status = 3'h6;
    cyc(4);
    chk(pin, 3'h0);
  endtask : t_weak
  task automatic t_od;
    do_reset(1'b1);
    status = 3'h6;
    fine = 10'h00a;
    cyc(4);
    chk(lvl, 3'h0);
    chk(oe_n, 3'h0);
    fine = 10'h00e;
    cyc(3);
    chk(oe_n, 3'h1);
    chk(cnt, 16'h0001);
  endtask : t_od
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run
  // Main sequence
  initial
  begin
    errors = 0;
    check_count = 0;
    do_reset(1'b0);
    t_lock;
    t_fwd;
    t_rev;
    t_hyst;
    t_weak;
    t_od;
    complete_run;
  end
  // Watchdog: about seven times the expected run
  initial
  begin
    #200000;
    errors++;
    complete_run;
  end
endmodule : qie_out_stage_tb
